/* File: rtl/rsd_ctrl.sv */
// Reference monitoring, selection and primary DPLL state control
// What this block does
// - Primary DPLL moves among free-run, locked, holdover without software.
// - Leaves free-run for locked once any reference with a nonzero primary priority is valid.
// - While locked, averages frequency over one second for holdover.
// - Loss of selected reference is detected fast; enters holdover.
// - From holdover, picks another valid reference and relocks hitlessly.
// - Selection is revertive or nonrevertive by configuration.
// - With all references lost, stays in holdover at stored frequency.
// - Monitors up to eight inputs for activity and frequency accuracy.
// - Separate priority tables per DPLL; each gets highest-priority valid input, except that a nonrevertive primary keeps its current one.
// - Selected reference may be divided down for the DPLL.
// - Fast monitor disqualifies selected reference after two missing cycles.
// - Master clock is local oscillator times sixteen.
// - Watchdog detects local oscillator failure and alerts the processor.
// - Both DPLLs lock at 8kHz to multiples of 8kHz.
// - Primary bandwidth 0.1Hz to 400Hz, separate acquisition and locked settings.
// - Damping selectable among 1.2, 2.5, 5, 10 and 20.
// - Phase detector: full-cycle phase/frequency or half-cycle nearest edge.
// - Multicycle phase detection tracks up to 8191 UI either way.
// - Reference change triggers phase build-out hiding old/new phase offset.
// - Output phase adjustable +/-200ns in 6ps steps.
// - Single-ended inputs accepted at multiples of 2kHz up to 125MHz.
// - Primary path makes 8kHz frame sync and 2kHz multiframe sync.
`timescale 1ns/1ps
module rsd_ctrl import rsd_pkg::*; #(
    parameter int AVG_CYCLES = AVG_CYC
) (
    input wire logic MCLK, // 100 MHz clock
    input wire logic RST, // Async reset, active high
    input wire logic [N_REF-1:0] REF_EDGE, // Per-input edge seen this cycle
    input wire logic [N_REF-1:0] REF_FREQ_OK, // Per-input frequency within range
    input wire logic [N_REF-1:0] REF_EN, // Per-input enable for selection
    input wire logic [N_REF*4-1:0] PRI_TABLE, // Primary priority per input, 0 = unused
    input wire logic [N_REF*4-1:0] SEC_TABLE, // Secondary priority per input, 0 = unused
    input wire logic REVERTIVE, // 1 = revertive selection
    input wire logic [7:0] REF_DIV, // Divide ratio minus one for the selected reference
    input wire logic OSC_EDGE, // Local oscillator edge seen this cycle
    input wire logic [FREQ_W-1:0] FREQ_WORD, // Primary DPLL instantaneous frequency
    input wire logic signed [14:0] MC_ERR, // Multicycle phase error in UI
    input wire rsd_loop_cfg_t LOOP_CFG, // Loop configuration
    output rsd_state_t PRI_STATE, // Primary DPLL state
    output logic [N_REF-1:0] REF_VALID, // Per-input validity
    output logic [3:0] PRI_SEL, // Primary selected input, F = none
    output logic [3:0] SEC_SEL, // Secondary selected input, F = none
    output logic PRI_DIV_CLK, // Divided selected reference strobe
    output logic [FREQ_W-1:0] HOLD_FREQ, // Stored holdover frequency
    output rsd_loop_out_t LOOP_OUT, // Active loop settings
    output logic signed [14:0] MC_TRACK, // Clamped multicycle error
    output logic OSC_FAIL, // Local oscillator failure alert
    output logic FSYNC, // 8kHz frame sync pulse
    output logic MFSYNC // 2kHz multiframe sync pulse
);
    // Per-input activity watch; gap limit assumes the input rate is at least 1/16 of MCLK
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_LIM = 8'(MISS_CYCLES * 16);
    logic [GAP_W-1:0] gap_ff [N_REF];
    logic [GAP_W-1:0] nxt_gap [N_REF];
    logic [N_REF-1:0] valid_ff, nxt_valid;
    always_comb begin
        for (int i = 0; i < N_REF; i++) begin
            nxt_gap[i] = REF_EDGE[i] ? '0 : (gap_ff[i] == GAP_LIM ? gap_ff[i] : gap_ff[i] + 8'h01);
            nxt_valid[i] = REF_EN[i] && REF_FREQ_OK[i] && (nxt_gap[i] < GAP_LIM);
        end
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            // Start as inactive so an input must show an edge before it can be valid
            for (int i = 0; i < N_REF; i++) gap_ff[i] <= GAP_LIM;
            valid_ff <= '0;
        end else begin
            for (int i = 0; i < N_REF; i++) gap_ff[i] <= nxt_gap[i];
            valid_ff <= nxt_valid;
        end
    end
    // Best valid input: lowest nonzero priority number wins, lowest index on ties
    function automatic logic [3:0] best_ref(input logic [N_REF*4-1:0] tbl, input logic [N_REF-1:0] ok);
        logic [3:0] sel;
        logic [3:0] bp;
        sel = NO_REF;
        bp = 4'hF;
        for (int i = 0; i < N_REF; i++) begin
            if (ok[i] && tbl[i*4 +: 4] != 4'h0 && (sel == NO_REF || tbl[i*4 +: 4] < bp)) begin
                sel = 4'(i);
                bp = tbl[i*4 +: 4];
            end
        end
        return sel;
    endfunction
    function automatic logic [3:0] prio_of(input logic [N_REF*4-1:0] tbl, input logic [3:0] idx);
        return (idx == NO_REF) ? 4'hF : tbl[idx[2:0]*4 +: 4];
    endfunction
    logic [3:0] pri_best, sec_best;
    assign pri_best = best_ref(PRI_TABLE, valid_ff);
    assign sec_best = best_ref(SEC_TABLE, valid_ff);
    // Primary state machine
    rsd_state_t state_ff, nxt_state;
    logic [3:0] psel_ff, nxt_psel, ssel_ff, nxt_ssel;
    logic bo_ff, nxt_bo;
    logic cur_ok;
    assign cur_ok = (psel_ff != NO_REF) && valid_ff[psel_ff[2:0]];
    always_comb begin
        nxt_state = state_ff;
        nxt_psel = psel_ff;
        nxt_bo = 1'b0;
        nxt_ssel = sec_best;
        case (state_ff)
            ST_FREE: begin
                if (pri_best != NO_REF) begin
                    nxt_state = ST_LOCK;
                    nxt_psel = pri_best;
                end
            end
            ST_LOCK: begin
                if (!cur_ok) begin
                    nxt_state = ST_HOLD;
                    nxt_psel = NO_REF;
                end else if (REVERTIVE && pri_best != psel_ff
                             && prio_of(PRI_TABLE, pri_best) < prio_of(PRI_TABLE, psel_ff)) begin
                    nxt_psel = pri_best;
                    nxt_bo = 1'b1;
                end
            end
            ST_HOLD: begin
                if (pri_best != NO_REF) begin
                    nxt_state = ST_LOCK;
                    nxt_psel = pri_best;
                    nxt_bo = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_FREE;
                nxt_psel = NO_REF;
            end
        endcase
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_ff <= ST_FREE;
            psel_ff <= NO_REF;
            ssel_ff <= NO_REF;
            bo_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            psel_ff <= nxt_psel;
            ssel_ff <= nxt_ssel;
            bo_ff <= nxt_bo;
        end
    end
    // Holdover averaging: one-second accumulate, then store the mean
    logic [FREQ_W+31:0] acc_ff, nxt_acc;
    logic [31:0] acnt_ff, nxt_acnt;
    logic [FREQ_W-1:0] hold_ff, nxt_hold;
    always_comb begin
        nxt_acc = acc_ff;
        nxt_acnt = acnt_ff;
        nxt_hold = hold_ff;
        if (state_ff != ST_LOCK) begin
            nxt_acc = '0; // Holdover keeps last stored value
            nxt_acnt = '0;
        end else if (acnt_ff == 32'(AVG_CYCLES - 1)) begin
            nxt_hold = FREQ_W'((acc_ff + (FREQ_W+32)'(FREQ_WORD)) / (FREQ_W+32)'(AVG_CYCLES));
            nxt_acc = '0;
            nxt_acnt = '0;
        end else begin
            nxt_acc = acc_ff + (FREQ_W+32)'(FREQ_WORD);
            nxt_acnt = acnt_ff + 32'h1;
        end
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_ff <= '0;
            acnt_ff <= '0;
            hold_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            acnt_ff <= nxt_acnt;
            hold_ff <= nxt_hold;
        end
    end
    // Reference divider; restarts on a selection change to avoid a short first period
    logic [7:0] dcnt_ff, nxt_dcnt;
    logic dclk_ff, nxt_dclk;
    logic sel_edge;
    assign sel_edge = (psel_ff != NO_REF) && REF_EDGE[psel_ff[2:0]];
    always_comb begin
        nxt_dcnt = dcnt_ff;
        nxt_dclk = 1'b0;
        if (nxt_bo || psel_ff == NO_REF) begin
            nxt_dcnt = '0;
        end else if (sel_edge) begin
            if (dcnt_ff == REF_DIV) begin
                nxt_dcnt = '0;
                nxt_dclk = 1'b1;
            end else begin
                nxt_dcnt = dcnt_ff + 8'h01;
            end
        end
    end
    // Oscillator watchdog and frame syncs
    logic [7:0] wdt_ff, nxt_wdt;
    logic ofail_ff, nxt_ofail;
    logic [15:0] fcnt_ff, nxt_fcnt;
    logic [1:0] mcnt_ff, nxt_mcnt;
    logic fs_ff, nxt_fs, mfs_ff, nxt_mfs;
    always_comb begin
        nxt_wdt = OSC_EDGE ? '0 : (wdt_ff == 8'(WDT_CYC) ? wdt_ff : wdt_ff + 8'h01);
        nxt_ofail = (nxt_wdt == 8'(WDT_CYC));
        nxt_fs = 1'b0;
        nxt_mfs = 1'b0;
        nxt_mcnt = mcnt_ff;
        if (fcnt_ff == 16'(FRAME_CYC - 1)) begin
            nxt_fcnt = '0;
            nxt_fs = 1'b1;
            nxt_mfs = (mcnt_ff == MFRAME_LAST);
            nxt_mcnt = mcnt_ff + 2'h1;
        end else begin
            nxt_fcnt = fcnt_ff + 16'h0001;
        end
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            dcnt_ff <= '0;
            dclk_ff <= 1'b0;
            wdt_ff <= '0;
            ofail_ff <= 1'b0;
            fcnt_ff <= '0;
            mcnt_ff <= '0;
            fs_ff <= 1'b0;
            mfs_ff <= 1'b0;
        end else begin
            dcnt_ff <= nxt_dcnt;
            dclk_ff <= nxt_dclk;
            wdt_ff <= nxt_wdt;
            ofail_ff <= nxt_ofail;
            fcnt_ff <= nxt_fcnt;
            mcnt_ff <= nxt_mcnt;
            fs_ff <= nxt_fs;
            mfs_ff <= nxt_mfs;
        end
    end
    // Loop settings: acquisition bandwidth until locked and during build-out
    function automatic logic signed [PADJ_W-1:0] clamp_adj(input logic signed [PADJ_W-1:0] v);
        if (v > PADJ_MAX) return PADJ_MAX;
        if (v < -PADJ_MAX) return -PADJ_MAX;
        return v;
    endfunction
    rsd_loop_out_t loop_ff, nxt_loop;
    logic signed [14:0] mc_ff, nxt_mc;
    always_comb begin
        nxt_loop.bw = (state_ff == ST_LOCK && !bo_ff) ? LOOP_CFG.lock_bw : LOOP_CFG.acq_bw;
        nxt_loop.damping = (LOOP_CFG.damping > DAMP_MAX) ? DAMP_MAX : LOOP_CFG.damping;
        nxt_loop.pd_mode = (LOOP_CFG.pd_mode == PD_NEAR) ? PD_NEAR :
                           (LOOP_CFG.pd_mode == PD_MULTI) ? PD_MULTI : PD_PFD;
        nxt_loop.phase_adj = clamp_adj(LOOP_CFG.phase_adj);
        nxt_loop.build_out = bo_ff;
        nxt_mc = (MC_ERR > MC_MAX) ? MC_MAX : (MC_ERR < -MC_MAX) ? -MC_MAX : MC_ERR;
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            loop_ff <= '0;
            mc_ff <= '0;
        end else begin
            loop_ff <= nxt_loop;
            mc_ff <= nxt_mc;
        end
    end
    assign PRI_STATE = state_ff;
    assign REF_VALID = valid_ff;
    assign PRI_SEL = psel_ff;
    assign SEC_SEL = ssel_ff;
    assign PRI_DIV_CLK = dclk_ff;
    assign HOLD_FREQ = hold_ff;
    assign LOOP_OUT = loop_ff;
    assign MC_TRACK = mc_ff;
    assign OSC_FAIL = ofail_ff;
    assign FSYNC = fs_ff;
    assign MFSYNC = mfs_ff;
    sequence ref_lost_s;
        (state_ff == ST_LOCK) && !cur_ok;
    endsequence
    free_to_lock_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_ff == ST_FREE && pri_best != NO_REF) |=> (state_ff == ST_LOCK && psel_ff == $past(pri_best)))
        else $error("free-run did not lock");
    lose_to_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        ref_lost_s |=> state_ff == ST_HOLD)
        else $error("lost reference did not enter holdover");
    hold_relock_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_ff == ST_HOLD && pri_best != NO_REF) |=> (state_ff == ST_LOCK && bo_ff))
        else $error("holdover did not relock");
    hold_stays_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_ff == ST_HOLD && valid_ff == '0) |=> (state_ff == ST_HOLD && $stable(hold_ff)))
        else $error("holdover left with no reference");
    nonrev_keep_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_ff == ST_LOCK && cur_ok && !REVERTIVE) |=> $stable(psel_ff))
        else $error("nonrevertive switched reference");
    miss_disq_a: assert property (@(posedge MCLK) disable iff (RST)
        (gap_ff[0] == GAP_LIM - 8'h01 && !REF_EDGE[0]) |=> !valid_ff[0])
        else $error("input not disqualified after gap");
    sec_select_a: assert property (@(posedge MCLK) disable iff (RST)
        1'b1 |=> ssel_ff == $past(sec_best))
        else $error("secondary selection wrong");
    fsync_space_a: assert property (@(posedge MCLK) disable iff (RST)
        FSYNC |=> !FSYNC [*8])
        else $error("frame sync too close");
    padj_range_a: assert property (@(posedge MCLK) disable iff (RST)
        LOOP_OUT.phase_adj <= PADJ_MAX && LOOP_OUT.phase_adj >= -PADJ_MAX)
        else $error("phase adjust out of range");
    wdt_alert_a: assert property (@(posedge MCLK) disable iff (RST)
        OSC_EDGE |=> !OSC_FAIL)
        else $error("watchdog alert with oscillator running");
endmodule // rsd_ctrl

/* File: shared/rsd_pkg.sv */
// Package for the reference select and DPLL state control block
package rsd_pkg;
    localparam int N_REF = 8;
    localparam int MCLK_HZ = 100000000;
    // Holdover averaging interval, in milliseconds
    localparam int AVG_MS = 1000;
    localparam int AVG_CYC = MCLK_HZ / 1000 * AVG_MS;
    // Fast activity monitor: missing cycles that disqualify the reference
    localparam int MISS_CYCLES = 2;
    // Oscillator watchdog: MCLK cycles without an oscillator edge
    localparam int WDT_CYC = 64;
    // Master clock multiplier applied to the local oscillator
    localparam int MCLK_MULT = 16;
    // Frame syncs: 8kHz frame and 2kHz multiframe (four frames)
    localparam int FRAME_HZ = 8000;
    localparam int FRAME_CYC = MCLK_HZ / FRAME_HZ;
    localparam logic [1:0] MFRAME_LAST = 2'h3;
    // Bandwidth code: 0 means 0.1Hz, top code means 400Hz
    localparam int BW_W = 5;
    localparam logic [BW_W-1:0] BW_MAX = 5'h1F;
    // Damping codes 0..4: 1.2, 2.5, 5, 10, 20
    localparam logic [2:0] DAMP_MAX = 3'h4;
    localparam int PHASE_W = 16;
    // Phase adjust in 6ps steps, limited to +/-200ns
    localparam int PADJ_PS = 6;
    localparam int PADJ_LIM_PS = 200000;
    // 17 bits: +/-33333 steps does not fit a signed 16-bit field
    localparam int PADJ_W = 17;
    localparam logic signed [PADJ_W-1:0] PADJ_MAX = PADJ_W'(PADJ_LIM_PS / PADJ_PS);
    // Multicycle range +/-8191 unit intervals
    localparam logic signed [14:0] MC_MAX = 15'h1FFF;
    localparam int FREQ_W = 32;
    localparam logic [3:0] NO_REF = 4'hF;
    typedef enum logic [1:0] {
        ST_FREE = 2'b00,
        ST_LOCK = 2'b01,
        ST_HOLD = 2'b10
    } rsd_state_t;
    typedef enum logic [1:0] {
        PD_PFD = 2'b00,
        PD_NEAR = 2'b01,
        PD_MULTI = 2'b10
    } rsd_pd_t;
    typedef struct packed {
        logic [BW_W-1:0] acq_bw;
        logic [BW_W-1:0] lock_bw;
        logic [2:0] damping;
        rsd_pd_t pd_mode;
        logic signed [PADJ_W-1:0] phase_adj;
    } rsd_loop_cfg_t;
    typedef struct packed {
        logic [BW_W-1:0] bw;
        logic [2:0] damping;
        rsd_pd_t pd_mode;
        logic signed [PADJ_W-1:0] phase_adj;
        logic build_out;
    } rsd_loop_out_t;
endpackage

/* File: bench/rsd_ref_model.sv */
// Source model for the timing-card references and the local oscillator
`timescale 1ns/1ps
module rsd_ref_model import rsd_pkg::*; (
    input wire logic clk, // Master clock
    input wire logic rst, // Async reset, active high
    input wire logic [N_REF-1:0] alive, // Source running
    input wire logic [N_REF-1:0] slow, // Source at one edge per 16 cycles
    input wire logic osc_on, // Local oscillator running
    output logic [N_REF-1:0] ref_edge, // Edge seen per source
    output logic osc_edge // Oscillator edge seen
);
    logic [3:0] cnt_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    // A pulled card gives no edges; slow sources stay inside the 32-cycle gap limit
    always_comb begin
        for (int i = 0; i < N_REF; i++) begin
            ref_edge[i] = alive[i] & (slow[i] ? (cnt_ff == 4'h0) : cnt_ff[0]);
        end
        osc_edge = osc_on & (cnt_ff[1:0] == 2'h0);
    end
endmodule // rsd_ref_model

/* File: bench/rsd_ctrl_tb_top.sv */
// Self-checking testbench for the reference select and state control block
`timescale 1ns/1ps
module rsd_ctrl_tb_top import rsd_pkg::*;;
    typedef struct {int id; logic [31:0] exp;} rsd_note_t;
    logic mclk = 1'b0, rst = 1'b1, revertive, osc_on, osc_edge, div_clk, osc_fail, fsync, mfsync;
    logic [7:0] freq_ok, en, alive, slow, ref_div, ref_edge, ref_valid;
    logic [31:0] pri_tab, sec_tab, freq_word, hold_freq, fv;
    logic signed [14:0] mc_err, mc_track;
    logic [3:0] pri_sel, sec_sel;
    rsd_state_t pri_state;
    rsd_loop_cfg_t cfg;
    rsd_loop_out_t loop_out;
    logic [31:0] meas [0:15];
    int num_errors = 0, check_count = 0, bo_cnt = 0, cyc = 0, fs_cnt = 0;
    rsd_note_t q[$];
    event sample_ev;
    string names [0:14] = '{"state", "pri_sel", "sec_sel", "valid", "hold_freq", "osc_fail", "damping",
        "mc_track", "phase_adj", "bw", "pd_mode", "div_gap", "fsyncs", "mf_gap", "buildouts"};

    always #5 mclk = ~mclk;

    rsd_ref_model src (.clk(mclk), .rst(rst), .alive(alive), .slow(slow), .osc_on(osc_on),
        .ref_edge(ref_edge), .osc_edge(osc_edge));
    rsd_ctrl #(.AVG_CYCLES(16)) dut (.MCLK(mclk), .RST(rst), .REF_EDGE(ref_edge), .REF_FREQ_OK(freq_ok),
        .REF_EN(en), .PRI_TABLE(pri_tab), .SEC_TABLE(sec_tab), .REVERTIVE(revertive), .REF_DIV(ref_div),
        .OSC_EDGE(osc_edge), .FREQ_WORD(freq_word), .MC_ERR(mc_err), .LOOP_CFG(cfg), .PRI_STATE(pri_state),
        .REF_VALID(ref_valid), .PRI_SEL(pri_sel), .SEC_SEL(sec_sel), .PRI_DIV_CLK(div_clk),
        .HOLD_FREQ(hold_freq), .LOOP_OUT(loop_out), .MC_TRACK(mc_track), .OSC_FAIL(osc_fail),
        .FSYNC(fsync), .MFSYNC(mfsync));

    always @(posedge mclk) if (loop_out.build_out === 1'b1) bo_cnt <= bo_cnt + 1;
    always @(posedge mclk) if (!rst) cyc <= cyc + 1;
    always @(posedge mclk) if (fsync === 1'b1) fs_cnt <= fs_cnt + 1;

    function automatic logic [31:0] got(input int id);
        case (id)
            0: return {30'h0, pri_state};
            1: return {28'h0, pri_sel};
            2: return {28'h0, sec_sel};
            3: return {24'h0, ref_valid};
            4: return hold_freq;
            5: return {31'h0, osc_fail};
            6: return {29'h0, loop_out.damping};
            7: return {17'h0, mc_track};
            8: return {15'h0, loop_out.phase_adj};
            9: return {27'h0, loop_out.bw};
            10: return {30'h0, loop_out.pd_mode};
            default: return meas[id];
        endcase
    endfunction

    task automatic note(input int id, input logic [31:0] exp);
        q.push_back('{id, exp});
        ->sample_ev;
    endtask

    // Bounded poll at the falling edge, then the note is judged by the monitor
    task automatic wait_for(input int id, input logic [31:0] exp, input int lim);
        for (int i = 0; i < lim && got(id) !== exp; i++) @(negedge mclk);
        note(id, exp);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rsd_note_t nt;
        forever begin
            @(sample_ev);
            while (q.size() > 0) begin
                nt = q.pop_front();
                check_count++;
                if (got(nt.id) !== nt.exp) begin
                    num_errors++;
                    $display("CHECK FAILED %s expected %h got %h", names[nt.id], nt.exp, got(nt.id));
                end
            end
        end
    end

    initial begin
        #600000;
        num_errors++;
        conclude();
    end

    initial begin
        int n;
        logic [2:0] dmp [0:2];
        logic signed [14:0] mci [0:2];
        logic signed [14:0] mce [0:2];
        logic signed [16:0] pa, pe;
        void'($urandom(44007));
        freq_ok = 8'hFF; en = 8'hFF; alive = 8'h00; slow = 8'h04; osc_on = 1'b1; revertive = 1'b0;
        pri_tab = 32'h00100200; sec_tab = 32'h00300100; ref_div = 8'h03; mc_err = 15'h0000;
        freq_word = $urandom;
        fv = freq_word;
        cfg = '{acq_bw: 5'h03, lock_bw: 5'h1F, damping: 3'h2, pd_mode: PD_PFD, phase_adj: 17'h1FF9C};
        dmp = '{3'h4, 3'h6, 3'h0};
        mci = '{15'h2328, 15'h5CD8, 15'h0000};
        mce = '{15'h1FFF, 15'h6001, 15'h0000};
        mci[2] = 15'($urandom_range(0, 8191));
        mce[2] = mci[2];
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        note(0, ST_FREE); note(1, 32'hF); note(2, 32'hF); note(3, 32'h0);
        @(posedge mclk);
        alive <= 8'h25;
        @(negedge mclk);
        wait_for(0, ST_LOCK, 60);
        note(1, 32'h5);
        // The slow input shows its first edge up to 16 cycles after the fast one
        wait_for(3, 32'h25, 40);
        wait_for(2, 32'h2, 4);
        repeat (4) @(negedge mclk);
        note(9, 32'h1F);
        for (n = 0; n < 40 && div_clk !== 1'b1; n++) @(negedge mclk);
        n = 0;
        do begin @(negedge mclk); n++; end while (div_clk !== 1'b1 && n < 40);
        meas[11] = n;
        note(11, 32'h8);
        repeat (40) @(negedge mclk);
        note(4, fv);
        @(posedge mclk);
        alive <= 8'h04;
        @(negedge mclk);
        wait_for(3, 32'h04, 60);
        @(negedge mclk);
        note(0, ST_HOLD); note(1, 32'hF);
        meas[14] = bo_cnt;
        wait_for(0, ST_LOCK, 10);
        note(1, 32'h2); note(4, fv);
        repeat (5) @(negedge mclk);
        meas[14] = bo_cnt - meas[14];
        note(14, 32'h1);
        @(posedge mclk);
        alive <= 8'h25;
        repeat (60) @(negedge mclk);
        note(1, 32'h2);
        @(posedge mclk);
        revertive <= 1'b1;
        @(negedge mclk);
        wait_for(1, 32'h5, 10);
        // Loss by enable on one input and by frequency on the others
        @(posedge mclk);
        en <= 8'hDF;
        freq_ok <= 8'hFA;
        @(negedge mclk);
        wait_for(0, ST_HOLD, 10);
        repeat (40) @(negedge mclk);
        note(1, 32'hF); note(3, 32'h0); note(4, fv); note(9, 32'h03);
        for (int i = 0; i < 3; i++) begin
            // Two draws past the limit and one inside it, so the clamp is exercised both ways
            pe = 17'($urandom_range(1, 16000));
            pa = (i == 0) ? PADJ_MAX + pe : (i == 1) ? -PADJ_MAX - pe : pe - 17'sh01F40;
            pe = (pa > PADJ_MAX) ? PADJ_MAX : (pa < -PADJ_MAX) ? -PADJ_MAX : pa;
            @(posedge mclk);
            cfg.pd_mode <= rsd_pd_t'(i);
            cfg.damping <= dmp[i];
            cfg.phase_adj <= pa;
            mc_err <= mci[i];
            repeat (2) @(negedge mclk);
            note(10, 32'(i));
            note(6, {29'h0, (i == 1) ? 3'h4 : dmp[i]});
            note(7, {17'h0, mce[i]});
            note(8, {15'h0, pe});
        end
        @(posedge mclk);
        osc_on <= 1'b0;
        repeat (40) @(negedge mclk);
        note(5, 32'h0);
        wait_for(5, 32'h1, 40);
        @(posedge mclk);
        osc_on <= 1'b1;
        @(negedge mclk);
        wait_for(5, 32'h0, 10);
        // First multiframe mark lands four frames after reset; waiting for a second would double the run
        for (n = 0; n < 50010 && mfsync !== 1'b1; n++) @(negedge mclk);
        meas[13] = cyc;
        @(negedge mclk);
        meas[12] = fs_cnt;
        note(13, 32'(4 * FRAME_CYC)); note(12, 32'h4);
        @(negedge mclk);
        conclude();
    end
endmodule // rsd_ctrl_tb_top
